// ===== src/lgops_datapath.v
// Operation
// - bitwise and, or, xor, invert per bit
// - acc forms take dir/ind/reg/imm operand
// - memory-destination forms leave accumulator untouched
// - plain rotates wrap end bit around
// - carry rotates include carry in ring
// - nibble swap changes nothing else
// - move copies byte bypassing accumulator
// - upper RAM indirect only, SFR direct only
// - push increments pointer, then stores
// - push/pop operand direct, stack indirect
// - stack may enter upper RAM, never SFR
// - immediate load of full data pointer
// - full byte exchange with accumulator
// - low nibble exchange via R0/R1 only
// - indirect address from R0, R1 or pointer
`include "lgops_regs.vh"
module lgops_datapath (
  input wire i_clk,
  input wire i_reset,
  input wire i_start,
  input wire [4:0] i_op,
  input wire [1:0] i_src_mode,
  input wire [1:0] i_dst_mode,
  input wire [1:0] i_ptr_sel,
  input wire [7:0] i_src_field,
  input wire [7:0] i_dst_field,
  input wire [15:0] i_imm16,
  input wire [1:0] i_bank,
  input wire i_carry,
  input wire [7:0] i_mem_rdata,
  input wire [7:0] i_r0,
  input wire [7:0] i_r1,
  output reg o_busy,
  output reg o_done,
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg o_mem_space,
  output reg [7:0] o_mem_addr,
  output reg [7:0] o_mem_wdata,
  output reg [7:0] o_acc,
  output reg o_carry,
  output reg [7:0] o_stack_pointer,
  output reg [15:0] o_data_pointer_16
);
  // ----------------------------------------------------------------
  // state machine
  // ----------------------------------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD1 = 5'h02;
  localparam [4:0] S_RD2 = 5'h04;
  localparam [4:0] S_WR = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  reg [4:0] state;
  reg [4:0] op;
  reg [1:0] src_mode;
  reg [1:0] dst_mode;
  reg [1:0] ptr_sel;
  reg [7:0] src_field;
  reg [7:0] dst_field;
  reg [1:0] bank;
  reg [7:0] opnd;
  wire [7:0] alu_res;
  wire alu_carry;

  // ----------------------------------------------------------------
  // address decoding
  // ----------------------------------------------------------------
  // register form: bank base plus register number
  function [7:0] reg_addr;
    input [1:0] b;
    input [2:0] n;
    begin
      reg_addr = {3'h0, b, n};
    end
  endfunction

  // indirect always lands in RAM space, so upper RAM is reachable and SFR never
  function [7:0] ind_addr;
    input [1:0] sel;
    input [7:0] r0;
    input [7:0] r1;
    input [7:0] sp;
    begin
      case (sel)
        `LGOPS_PTR_R0: ind_addr = r0;
        `LGOPS_PTR_R1: ind_addr = r1;
        default: ind_addr = sp;
      endcase
    end
  endfunction

  // direct addresses at or above the boundary are SFRs
  function dir_space;
    input [7:0] a;
    begin
      dir_space = (a >= `LGOPS_SFR_BASE) ? `LGOPS_SPACE_SFR : `LGOPS_SPACE_RAM;
    end
  endfunction

  lgops_logic_unit u_alu (
    .i_op(op),
    .i_a((op == `LGOPS_OP_AND_MI || op == `LGOPS_OP_OR_MI || op == `LGOPS_OP_XOR_MI ||
          op == `LGOPS_OP_AND_MA || op == `LGOPS_OP_OR_MA || op == `LGOPS_OP_XOR_MA)
         ? opnd : o_acc),
    .i_b((op == `LGOPS_OP_AND_MI || op == `LGOPS_OP_OR_MI || op == `LGOPS_OP_XOR_MI)
         ? dst_field : ((op == `LGOPS_OP_AND_MA || op == `LGOPS_OP_OR_MA ||
         op == `LGOPS_OP_XOR_MA) ? o_acc : opnd)),
    .i_carry(o_carry),
    .o_res(alu_res),
    .o_carry(alu_carry)
  );

  // issue a read of the source operand per its addressing mode
  task issue_src_read;
    begin
      o_mem_rd <= 1'b1;
      case (src_mode)
        `LGOPS_MODE_IND: begin
          o_mem_space <= `LGOPS_SPACE_RAM;
          o_mem_addr <= ind_addr(ptr_sel, i_r0, i_r1, o_stack_pointer);
        end
        `LGOPS_MODE_REG: begin
          o_mem_space <= `LGOPS_SPACE_RAM;
          o_mem_addr <= reg_addr(bank, src_field[2:0]);
        end
        default: begin
          o_mem_space <= dir_space(src_field);
          o_mem_addr <= src_field;
        end
      endcase
    end
  endtask

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= S_IDLE;
      op <= `LGOPS_OP_NOP;
      src_mode <= `LGOPS_MODE_DIR;
      dst_mode <= `LGOPS_MODE_DIR;
      ptr_sel <= `LGOPS_PTR_R0;
      src_field <= 8'h00;
      dst_field <= 8'h00;
      bank <= 2'h0;
      opnd <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_mem_space <= `LGOPS_SPACE_RAM;
      o_mem_addr <= 8'h00;
      o_mem_wdata <= 8'h00;
      o_acc <= `LGOPS_ACC_RST;
      o_carry <= 1'b0;
      o_stack_pointer <= `LGOPS_SP_RST;
      o_data_pointer_16 <= `LGOPS_DP_RST;
    end else begin
      o_done <= 1'b0;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_start) begin
            op <= i_op;
            src_mode <= i_src_mode;
            dst_mode <= i_dst_mode;
            ptr_sel <= i_ptr_sel;
            src_field <= i_src_field;
            dst_field <= i_dst_field;
            bank <= i_bank;
            o_carry <= i_carry;
            o_busy <= 1'b1;
            state <= S_RD1;
          end
        end
        S_RD1: begin
          state <= S_RD2;
          case (op)
            `LGOPS_OP_AND_A, `LGOPS_OP_OR_A, `LGOPS_OP_XOR_A: begin
              if (src_mode == `LGOPS_MODE_IMM) begin
                opnd <= src_field;
                state <= S_WR;
              end else begin
                issue_src_read;
              end
            end
            `LGOPS_OP_AND_MA, `LGOPS_OP_OR_MA, `LGOPS_OP_XOR_MA,
            `LGOPS_OP_AND_MI, `LGOPS_OP_OR_MI, `LGOPS_OP_XOR_MI: begin
              src_mode <= `LGOPS_MODE_DIR;
              o_mem_rd <= 1'b1;
              o_mem_space <= dir_space(src_field);
              o_mem_addr <= src_field;
            end
            `LGOPS_OP_MOV, `LGOPS_OP_XCH: issue_src_read;
            `LGOPS_OP_SWAP_LOW_NIBBLE: begin
              o_mem_rd <= 1'b1;
              o_mem_space <= `LGOPS_SPACE_RAM;
              o_mem_addr <= ind_addr({1'b0, ptr_sel[0]}, i_r0, i_r1, o_stack_pointer);
            end
            `LGOPS_OP_POP: begin
              o_mem_rd <= 1'b1;
              o_mem_space <= `LGOPS_SPACE_RAM;
              o_mem_addr <= o_stack_pointer;
            end
            `LGOPS_OP_PUSH: begin
              o_mem_rd <= 1'b1;
              o_mem_space <= dir_space(src_field);
              o_mem_addr <= src_field;
            end
            default: state <= S_WR;
          endcase
        end
        S_RD2: begin
          // memory answers within the read strobe cycle; data is taken at the edge that ends it
          opnd <= i_mem_rdata;
          state <= S_WR;
        end
        S_WR: begin
          state <= S_DONE;
          case (op)
            `LGOPS_OP_AND_A, `LGOPS_OP_OR_A, `LGOPS_OP_XOR_A,
            `LGOPS_OP_INV, `LGOPS_OP_RL, `LGOPS_OP_RR: o_acc <= alu_res;
            `LGOPS_OP_RLC, `LGOPS_OP_RRC: begin
              o_acc <= alu_res;
              o_carry <= alu_carry;
            end
            `LGOPS_OP_SWAPN: o_acc <= alu_res;
            `LGOPS_OP_AND_MA, `LGOPS_OP_OR_MA, `LGOPS_OP_XOR_MA,
            `LGOPS_OP_AND_MI, `LGOPS_OP_OR_MI, `LGOPS_OP_XOR_MI: begin
              o_mem_wr <= 1'b1;
              o_mem_wdata <= alu_res;
            end
            `LGOPS_OP_MOV: begin
              o_mem_wr <= 1'b1;
              o_mem_wdata <= opnd;
              if (dst_mode == `LGOPS_MODE_IND) begin
                o_mem_space <= `LGOPS_SPACE_RAM;
                o_mem_addr <= ind_addr(ptr_sel, i_r0, i_r1, o_stack_pointer);
              end else if (dst_mode == `LGOPS_MODE_REG) begin
                o_mem_space <= `LGOPS_SPACE_RAM;
                o_mem_addr <= reg_addr(bank, dst_field[2:0]);
              end else begin
                o_mem_space <= dir_space(dst_field);
                o_mem_addr <= dst_field;
              end
            end
            `LGOPS_OP_XCH: begin
              o_mem_wr <= 1'b1;
              o_mem_wdata <= o_acc;
              o_acc <= opnd;
            end
            `LGOPS_OP_SWAP_LOW_NIBBLE: begin
              o_mem_wr <= 1'b1;
              o_mem_wdata <= {opnd[7:4], o_acc[3:0]};
              o_acc <= {o_acc[7:4], opnd[3:0]};
            end
            `LGOPS_OP_PUSH: begin
              o_stack_pointer <= o_stack_pointer + 8'h01;
              o_mem_wr <= 1'b1;
              o_mem_space <= `LGOPS_SPACE_RAM;
              o_mem_addr <= o_stack_pointer + 8'h01;
              o_mem_wdata <= opnd;
            end
            `LGOPS_OP_POP: begin
              o_stack_pointer <= o_stack_pointer - 8'h01;
              o_mem_wr <= 1'b1;
              o_mem_space <= dir_space(src_field);
              o_mem_addr <= src_field;
              o_mem_wdata <= opnd;
            end
            `LGOPS_OP_LDDP: o_data_pointer_16 <= i_imm16;
            default: o_acc <= o_acc;
          endcase
        end
        S_DONE: begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // lgops_datapath

// ===== shared/lgops_regs.vh
`ifndef LGOPS_REGS_VH
`define LGOPS_REGS_VH
// operation codes
`define LGOPS_OP_WIDTH 5
`define LGOPS_OP_NOP 5'h00
`define LGOPS_OP_AND_A 5'h01
`define LGOPS_OP_OR_A 5'h02
`define LGOPS_OP_XOR_A 5'h03
`define LGOPS_OP_AND_MA 5'h04
`define LGOPS_OP_OR_MA 5'h05
`define LGOPS_OP_XOR_MA 5'h06
`define LGOPS_OP_AND_MI 5'h07
`define LGOPS_OP_OR_MI 5'h08
`define LGOPS_OP_XOR_MI 5'h09
`define LGOPS_OP_INV 5'h0A
`define LGOPS_OP_RL 5'h0B
`define LGOPS_OP_RLC 5'h0C
`define LGOPS_OP_RR 5'h0D
`define LGOPS_OP_RRC 5'h0E
`define LGOPS_OP_SWAPN 5'h0F
`define LGOPS_OP_MOV 5'h10
`define LGOPS_OP_LDDP 5'h11
`define LGOPS_OP_XCH 5'h12
`define LGOPS_OP_SWAP_LOW_NIBBLE 5'h13
`define LGOPS_OP_PUSH 5'h14
`define LGOPS_OP_POP 5'h15
// operand addressing modes
`define LGOPS_MODE_DIR 2'h0
`define LGOPS_MODE_IND 2'h1
`define LGOPS_MODE_REG 2'h2
`define LGOPS_MODE_IMM 2'h3
// indirect pointer selectors
`define LGOPS_PTR_R0 2'h0
`define LGOPS_PTR_R1 2'h1
`define LGOPS_PTR_SP 2'h2
// address space boundary and space codes
`define LGOPS_SFR_BASE 8'h80
`define LGOPS_SPACE_RAM 1'h0
`define LGOPS_SPACE_SFR 1'h1
// reset values
`define LGOPS_ACC_RST 8'h00
`define LGOPS_SP_RST 8'h07
`define LGOPS_DP_RST 16'h0000
`endif

// ===== src/lgops_logic_unit.v
`include "lgops_regs.vh"
module lgops_logic_unit (
  input wire [4:0] i_op,
  input wire [7:0] i_a,
  input wire [7:0] i_b,
  input wire i_carry,
  output reg [7:0] o_res,
  output reg o_carry
);
  always @* begin
    o_res = i_a;
    o_carry = i_carry;
    case (i_op)
      `LGOPS_OP_AND_A, `LGOPS_OP_AND_MA, `LGOPS_OP_AND_MI: o_res = i_a & i_b;
      `LGOPS_OP_OR_A, `LGOPS_OP_OR_MA, `LGOPS_OP_OR_MI: o_res = i_a | i_b;
      `LGOPS_OP_XOR_A, `LGOPS_OP_XOR_MA, `LGOPS_OP_XOR_MI: o_res = i_a ^ i_b;
      `LGOPS_OP_INV: o_res = ~i_a;
      `LGOPS_OP_RL: o_res = {i_a[6:0], i_a[7]};
      `LGOPS_OP_RR: o_res = {i_a[0], i_a[7:1]};
      `LGOPS_OP_RLC: begin
        o_res = {i_a[6:0], i_carry};
        o_carry = i_a[7];
      end
      `LGOPS_OP_RRC: begin
        o_res = {i_carry, i_a[7:1]};
        o_carry = i_a[0];
      end
      `LGOPS_OP_SWAPN: o_res = {i_a[3:0], i_a[7:4]};
      default: o_res = i_a;
    endcase
  end
endmodule // lgops_logic_unit

// ===== verif/lgops_mem_model.sv
module lgops_mem_model (
  input logic i_clk,
  input logic i_rd,
  input logic i_wr,
  input logic i_space,
  input logic [7:0] i_addr,
  input logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [256];
  logic [7:0] sfr [128];
  logic [7:0] rd_byte;
  initial begin
    for (int k = 0; k < 256; k++) ram[k] = k[7:0] ^ 8'h5A;
    for (int k = 0; k < 128; k++) sfr[k] = k[7:0] ^ 8'hC3;
  end
  // ----------------------------------------
  // storage port
  // ----------------------------------------
  // core latches read data at the edge that ends the strobe cycle, so answer within it;
  // off-strobe data is inverted so a mistimed capture never looks valid
  assign rd_byte = i_space ? sfr[i_addr[6:0]] : ram[i_addr];
  assign o_rdata = i_rd ? rd_byte : ~rd_byte;
  always @(posedge i_clk) begin
    if (i_wr && i_space) sfr[i_addr[6:0]] <= i_wdata;
    else if (i_wr) ram[i_addr] <= i_wdata;
  end
endmodule // lgops_mem_model

// ===== verif/lgops_datapath_assertions.sv
`include "lgops_regs.vh"
module lgops_datapath_chk (
  input logic i_clk,
  input logic i_reset,
  input logic i_start,
  input logic [4:0] i_op,
  input logic o_busy,
  input logic o_done,
  input logic o_mem_rd,
  input logic o_mem_wr,
  input logic o_mem_space,
  input logic [7:0] o_mem_addr,
  input logic [7:0] o_acc,
  input logic [7:0] o_stack_pointer
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic [7:0] acc_t;
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) acc_t <= 8'h00;
    else if (i_start && !o_busy) acc_t <= o_acc;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_take_busy: assert property (i_start && !o_busy |=> o_busy)
    else $error("busy not raised after take");
  a_done_bound: assert property ($rose(o_busy) |-> ##[3:4] o_done)
    else $error("done late");
  a_sfr_direct: assert property ((o_mem_rd || o_mem_wr) && o_mem_space |-> o_mem_addr[7])
    else $error("sfr access below 80h");
  a_push_store: assert property (o_mem_wr && o_stack_pointer == $past(o_stack_pointer) + 8'h01
    |-> !o_mem_space && o_mem_addr == o_stack_pointer) else $error("push store misplaced");
  a_rotate_left: assert property (o_done && i_op == `LGOPS_OP_RL
    |-> o_acc == {acc_t[6:0], acc_t[7]}) else $error("rotate left wrong");
  a_swap_nibble: assert property (o_done && i_op == `LGOPS_OP_SWAPN
    |-> o_acc == {acc_t[3:0], acc_t[7:4]}) else $error("nibble swap wrong");
  a_invert_acc: assert property (o_done && i_op == `LGOPS_OP_INV |-> o_acc == ~acc_t)
    else $error("invert wrong");
  a_mem_keeps_acc: assert property (o_done && i_op >= `LGOPS_OP_AND_MA
    && i_op <= `LGOPS_OP_XOR_MI |-> o_acc == acc_t) else $error("acc changed by memory op");
  c_sfr_write: cover property (o_mem_wr && o_mem_space);
  c_push: cover property (o_done && i_op == `LGOPS_OP_PUSH);
  c_nibble_xchg: cover property (o_done && i_op == `LGOPS_OP_SWAP_LOW_NIBBLE);
endmodule // lgops_datapath_chk
bind lgops_datapath lgops_datapath_chk chk (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start),
  .i_op(i_op), .o_busy(o_busy), .o_done(o_done), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
  .o_mem_space(o_mem_space), .o_mem_addr(o_mem_addr), .o_acc(o_acc),
  .o_stack_pointer(o_stack_pointer));

// ===== verif/tb_lgops_datapath.sv
`include "lgops_regs.vh"
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module tb_lgops_datapath;
  timeunit 1ns;
  timeprecision 1ns;
  // cc packs carry in (bit 1) with expected carry out (bit 0)
  typedef struct {logic [4:0] op; logic [1:0] sm, ps; logic [7:0] sf, df; logic [1:0] cc;
    logic [7:0] ea;} lgops_row;
  logic i_clk = 1'b0, i_reset = 1'b1, i_start = 1'b0, i_carry = 1'b0;
  logic [4:0] i_op = 5'h00;
  logic [1:0] i_src_mode = 2'h0, i_dst_mode = 2'h0, i_ptr_sel = 2'h0, i_bank = 2'h0;
  logic [7:0] i_src_field = 8'h00, i_dst_field = 8'h00, i_r0 = 8'h90, i_r1 = 8'h30;
  logic [7:0] i_mem_rdata, o_mem_addr, o_mem_wdata, o_acc, o_stack_pointer;
  logic [15:0] i_imm16 = 16'hA5C3, o_data_pointer_16;
  logic o_busy, o_done, o_mem_rd, o_mem_wr, o_mem_space, o_carry;
  logic [7:0] ma [10] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h08, 8'h41, 8'h42, 8'h3E, 8'h30};
  logic [7:0] mv [10] = '{8'h12, 8'hFB, 8'hEA, 8'h09, 8'h7F, 8'h12, 8'h12, 8'h64, 8'h92, 8'h64};
  lgops_row rows [27];
  int err_count = 0, total_checks = 0;
  always #5 i_clk = ~i_clk;
  lgops_datapath uut (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_op(i_op),
    .i_src_mode(i_src_mode), .i_dst_mode(i_dst_mode), .i_ptr_sel(i_ptr_sel),
    .i_src_field(i_src_field), .i_dst_field(i_dst_field), .i_imm16(i_imm16), .i_bank(i_bank),
    .i_carry(i_carry), .i_mem_rdata(i_mem_rdata), .i_r0(i_r0), .i_r1(i_r1), .o_busy(o_busy),
    .o_done(o_done), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_space(o_mem_space),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_acc(o_acc), .o_carry(o_carry),
    .o_stack_pointer(o_stack_pointer), .o_data_pointer_16(o_data_pointer_16));
  lgops_mem_model mem (.i_clk(i_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_space(o_mem_space),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // one operation, held until done
  // ----------------------------------------
  task automatic run(input lgops_row r);
    int n;
    @(negedge i_clk);
    {i_op, i_src_mode, i_ptr_sel, i_src_field, i_dst_field} = {r.op, r.sm, r.ps, r.sf, r.df};
    i_carry = r.cc[1];
    i_start = 1'b1;
    @(negedge i_clk);
    i_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 8) begin
      @(negedge i_clk);
      n++;
    end
    `CHK("done", 1'b1, o_done)
    `CHK("acc", r.ea, o_acc)
    `CHK("carry", r.cc[0], o_carry)
  endtask
  initial begin
    rows = '{'{5'h01, 2'h3, 2'h0, 8'h00, 8'h00, 2'h0, 8'h00}, '{5'h02, 2'h3, 2'h0, 8'h35, 8'h00, 2'h0, 8'h35},
      '{5'h01, 2'h3, 2'h0, 8'h53, 8'h00, 2'h0, 8'h11}, '{5'h03, 2'h3, 2'h0, 8'hFF, 8'h00, 2'h0, 8'hEE},
      '{5'h0A, 2'h0, 2'h0, 8'h00, 8'h00, 2'h0, 8'h11}, '{5'h0B, 2'h0, 2'h0, 8'h00, 8'h00, 2'h0, 8'h22},
      '{5'h0D, 2'h0, 2'h0, 8'h00, 8'h00, 2'h0, 8'h11}, '{5'h0C, 2'h0, 2'h0, 8'h00, 8'h00, 2'h2, 8'h23},
      '{5'h0E, 2'h0, 2'h0, 8'h00, 8'h00, 2'h1, 8'h11}, '{5'h02, 2'h3, 2'h0, 8'hC0, 8'h00, 2'h0, 8'hD1},
      '{5'h0F, 2'h0, 2'h0, 8'h00, 8'h00, 2'h0, 8'h1D}, '{5'h01, 2'h0, 2'h0, 8'h3E, 8'h00, 2'h0, 8'h04},
      '{5'h02, 2'h1, 2'h0, 8'h00, 8'h00, 2'h0, 8'hCE}, '{5'h03, 2'h2, 2'h0, 8'h06, 8'h00, 2'h0, 8'h92},
      '{5'h04, 2'h0, 2'h0, 8'h20, 8'h00, 2'h0, 8'h92}, '{5'h05, 2'h0, 2'h0, 8'h21, 8'h00, 2'h0, 8'h92},
      '{5'h06, 2'h0, 2'h0, 8'h22, 8'h00, 2'h0, 8'h92}, '{5'h07, 2'h0, 2'h0, 8'h23, 8'h0F, 2'h0, 8'h92},
      '{5'h08, 2'h0, 2'h0, 8'h24, 8'h01, 2'h0, 8'h92}, '{5'h09, 2'h0, 2'h0, 8'h90, 8'hFF, 2'h0, 8'h92},
      '{5'h14, 2'h0, 2'h0, 8'h20, 8'h00, 2'h0, 8'h92}, '{5'h15, 2'h0, 2'h0, 8'h41, 8'h00, 2'h0, 8'h92},
      '{5'h10, 2'h0, 2'h0, 8'h3E, 8'h42, 2'h0, 8'h92}, '{5'h11, 2'h0, 2'h0, 8'h00, 8'h00, 2'h0, 8'h92},
      '{5'h12, 2'h0, 2'h0, 8'h3E, 8'h00, 2'h0, 8'h64}, '{5'h13, 2'h1, 2'h1, 8'h00, 8'h00, 2'h0, 8'h6A},
      '{5'h02, 2'h1, 2'h2, 8'h00, 8'h00, 2'h0, 8'h7F}};
    repeat (3) @(posedge i_clk);
    @(negedge i_clk) i_reset = 1'b0;
    `CHK("sp reset", 8'h07, o_stack_pointer)
    `CHK("dp reset", 16'h0000, o_data_pointer_16)
    foreach (rows[k]) begin
      run(rows[k]);
      $display("row %0d finished", k);
    end
    for (int k = 0; k < 10; k++) `CHK("ram", mv[k], mem.ram[ma[k]])
    `CHK("sfr", 8'h2C, mem.sfr[7'h10])
    `CHK("sp", 8'h07, o_stack_pointer)
    `CHK("dp", 16'hA5C3, o_data_pointer_16)
    $display("memory test finished");
    // bank 1 register source into @R1, then direct source into a bank 1 register
    i_bank = 2'h1;
    i_dst_mode = `LGOPS_MODE_IND;
    run('{5'h10, 2'h2, 2'h1, 8'h03, 8'h00, 2'h0, 8'h7F});
    i_dst_mode = `LGOPS_MODE_REG;
    run('{5'h10, 2'h0, 2'h0, 8'h3E, 8'h05, 2'h0, 8'h7F});
    `CHK("mov reg to ind", 8'h51, mem.ram[8'h30])
    `CHK("mov dir to reg", 8'h92, mem.ram[8'h0D])
    $display("bank move test finished");
    @(negedge i_clk) i_reset = 1'b1;
    @(negedge i_clk) i_reset = 1'b0;
    `CHK("acc reset", 8'h00, o_acc)
    `CHK("sp rereset", 8'h07, o_stack_pointer)
    $display("reset test finished");
    wrap_up();
  end
  initial begin
    repeat (1000) @(posedge i_clk);
    err_count++;
    wrap_up();
  end
endmodule // tb_lgops_datapath
